// ==== core/phytxc_regs.sv ====
/*
 * Digital configuration and transmit control register bank with
 * its controlled outputs, reached over the parallel management port.
 * Assumes the serial management framing sits outside this block and
 * presents one-cycle read and write strobes with a 5-bit address.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Read/write bit raises MII output drive strength
// - Read/write bit routes raw symbol error out
// - Read/write bit forces transmitter low power, zero
// - Two-bit field selects one of four rise times
// - Rise-time field loaded from strap pins at reset
// - Reserved bits reset zero; some stay read-only

module phytxc_regs (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // Rise time strap pins, sampled while reset is held
    input  wire logic [1:0]  tx_edge_rate_strap_i,
    // Management register port
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic [15:0]      reg_rdata_o,
    output logic             reg_rvalid_o,
    // Receive error sources
    input  wire logic        rx_err_normal_i,
    input  wire logic        rx_symbol_err_i,
    // Controlled outputs
    output logic             mii_drive_high_o,
    output logic             mii_rx_err_o,
    output logic             tx_low_power_o,
    output logic             tx_zero_diff_o,
    output logic [1:0]       tx_edge_rate_o
);

    // Register contents
    logic [15:0] dcfg_q;   // Digital configuration word
    logic [15:0] txc_q;    // Transmit control word

    // Address match, used by both the write and read paths
    function automatic logic addr_is(input logic [4:0] addr,
                                     input logic [4:0] target);
        addr_is = (addr == target);
    endfunction

    // Write data kept to the writable bits only
    function automatic logic [15:0] masked(input logic [15:0] data,
                                           input logic [15:0] mask);
        masked = data & mask;
    endfunction

    // Digital configuration register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            // All bits come up clear
            dcfg_q <= phytxc_pkg::DCFG_RESET;
        end else if (reg_wr_i &&
                     addr_is(reg_addr_i, phytxc_pkg::DIG_CFG_ADDR)) begin
            // Read-only bits never take write data
            dcfg_q <= masked(reg_wdata_i,
                             phytxc_pkg::DCFG_WMASK);
        end
    end

    // Transmit control register; straps captured while reset is held
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            // Base reset value, then the strap overlay
            txc_q <= phytxc_pkg::TXC_RESET;
            txc_q[phytxc_pkg::TXC_EDGE_MSB:phytxc_pkg::TXC_EDGE_LSB]
                <= tx_edge_rate_strap_i;
        end else if (reg_wr_i &&
                     addr_is(reg_addr_i, phytxc_pkg::TX_CTL_ADDR)) begin
            // Unlisted bits stay clear
            txc_q <= masked(reg_wdata_i,
                            phytxc_pkg::TXC_WMASK);
        end
    end

    // Read path: data and valid one cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (!reg_rd_i) begin
                // Hold the last answer between reads
                reg_rdata_o <= reg_rdata_o;
            end else if (addr_is(reg_addr_i,
                                 phytxc_pkg::DIG_CFG_ADDR)) begin
                reg_rdata_o <= dcfg_q;
            end else if (addr_is(reg_addr_i,
                                 phytxc_pkg::TX_CTL_ADDR)) begin
                reg_rdata_o <= txc_q;
            end else begin
                // Unmapped offsets read as zero
                reg_rdata_o <= 16'h0000;
            end
        end
    end

    // Control bundle to the output stage
    phytxc_ctl_if ctl ();

    // Field extraction onto the bundle
    assign ctl.drive_high  = dcfg_q[phytxc_pkg::DCFG_DRIVE_BIT];
    assign ctl.show_symerr = dcfg_q[phytxc_pkg::DCFG_SHOW_BIT];
    assign ctl.low_power   = txc_q[phytxc_pkg::TXC_LOWPWR_BIT];
    assign ctl.edge_rate   =
        txc_q[phytxc_pkg::TXC_EDGE_MSB:phytxc_pkg::TXC_EDGE_LSB];

    // Registered output stage
    phytxc_out_stage u_out (
        .sys_clk_i        (sys_clk_i),
        .srst_i           (srst_i),
        .ctl              (ctl),
        .rx_err_normal_i  (rx_err_normal_i),
        .rx_symbol_err_i  (rx_symbol_err_i),
        .mii_drive_high_o (mii_drive_high_o),
        .mii_rx_err_o     (mii_rx_err_o),
        .tx_low_power_o   (tx_low_power_o),
        .tx_zero_diff_o   (tx_zero_diff_o),
        .tx_edge_rate_o   (tx_edge_rate_o)
    );

    // Write decode seen by the assertions
    logic wr_dcfg;   // Write to digital configuration
    logic wr_txc;    // Write to transmit control
    assign wr_dcfg = reg_wr_i &&
                     addr_is(reg_addr_i, phytxc_pkg::DIG_CFG_ADDR);
    assign wr_txc  = reg_wr_i &&
                     addr_is(reg_addr_i, phytxc_pkg::TX_CTL_ADDR);

    // Drive strength pin shows the written bit two clocks on
    property p_drive_follow;
        @(posedge sys_clk_i) disable iff (srst_i)
        wr_dcfg ##1 !srst_i |->
            ##1 mii_drive_high_o == $past(reg_wdata_i[11], 2);
    endproperty
    a_drive_follow: assert property (p_drive_follow)
        else $error("drive strength pin missed a register write");

    // Symbol error select takes effect in the register one clock on
    property p_show_store;
        @(posedge sys_clk_i) disable iff (srst_i)
        wr_dcfg |=> dcfg_q[9] == $past(reg_wdata_i[9]);
    endproperty
    a_show_store: assert property (p_show_store)
        else $error("symbol error select not stored");

    // Low power pin shows the written bit two clocks on
    property p_lowpwr_follow;
        @(posedge sys_clk_i) disable iff (srst_i)
        wr_txc ##1 !srst_i |->
            ##1 tx_low_power_o == $past(reg_wdata_i[12], 2);
    endproperty
    a_lowpwr_follow: assert property (p_lowpwr_follow)
        else $error("low power pin missed a register write");

    // Edge rate pins show the written field two clocks on
    property p_edge_follow;
        @(posedge sys_clk_i) disable iff (srst_i)
        wr_txc ##1 !srst_i |->
            ##1 tx_edge_rate_o == $past(reg_wdata_i[11:10], 2);
    endproperty
    a_edge_follow: assert property (p_edge_follow)
        else $error("edge rate pins missed a register write");

    // Edge field holds the strap level seen in the last reset cycle
    property p_strap_load;
        @(posedge sys_clk_i) disable iff (srst_i)
        $fell(srst_i) |->
            txc_q[11:10] == $past(tx_edge_rate_strap_i);
    endproperty
    a_strap_load: assert property (p_strap_load)
        else $error("edge rate field not loaded from straps");

    // Read-only bits of the digital configuration word read zero
    property p_ro_zero;
        @(posedge sys_clk_i) disable iff (srst_i)
        reg_rd_i && addr_is(reg_addr_i, phytxc_pkg::DIG_CFG_ADDR) |=>
            reg_rvalid_o && reg_rdata_o[8:6] == 3'h0 &&
            reg_rdata_o[3] == 1'b0;
    endproperty
    a_ro_zero: assert property (p_ro_zero)
        else $error("read-only bits read nonzero");

    // In the first cycle out of reset the drive strength and low power pins, the digital configuration word and the low power bit are clear
    property p_reset_clear;
        @(posedge sys_clk_i) disable iff (srst_i)
        $fell(srst_i) |->
            !mii_drive_high_o && !tx_low_power_o &&
            dcfg_q == 16'h0000 && txc_q[12] == 1'b0;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control bits not clear after reset");

    // Read-only and unlisted bits never hold a one
    property p_rsvd_zero;
        @(posedge sys_clk_i) disable iff (srst_i)
        (dcfg_q & ~phytxc_pkg::DCFG_WMASK) == 16'h0000 &&
            (txc_q & ~phytxc_pkg::TXC_WMASK) == 16'h0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("read-only bit holds a one");

    // Transmit control reads back its stored word
    property p_txc_readback;
        @(posedge sys_clk_i) disable iff (srst_i)
        reg_rd_i && addr_is(reg_addr_i, phytxc_pkg::TX_CTL_ADDR) |=>
            reg_rvalid_o && reg_rdata_o == $past(txc_q);
    endproperty
    a_txc_readback: assert property (p_txc_readback)
        else $error("transmit control read back wrong");

    // Zero differential output tracks the written low power bit
    property p_zero_diff_follow;
        @(posedge sys_clk_i) disable iff (srst_i)
        wr_txc ##1 !srst_i |->
            ##1 tx_zero_diff_o == $past(reg_wdata_i[12], 2);
    endproperty
    a_zero_diff_follow: assert property (p_zero_diff_follow)
        else $error("zero differential pin missed a register write");

endmodule

`default_nettype wire

// ==== core/phytxc_pkg.sv ====
/*
 * Constants shared by the transmit configuration register bank:
 * register offsets, field positions, write masks and reset values.
 * Assumes a 5-bit management register address and 16-bit data.
 */
package phytxc_pkg;

    // Register address and data widths
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    // Register offsets on the management port
    localparam logic [4:0] DIG_CFG_ADDR = 5'h1A;
    localparam logic [4:0] TX_CTL_ADDR  = 5'h1E;

    // Digital configuration field positions
    localparam int unsigned DCFG_DRIVE_BIT = 11;
    localparam int unsigned DCFG_SHOW_BIT  = 9;

    // Transmit control field positions
    localparam int unsigned TXC_LOWPWR_BIT = 12;
    localparam int unsigned TXC_EDGE_MSB   = 11;
    localparam int unsigned TXC_EDGE_LSB   = 10;

    // Writable bits; all others read as zero
    localparam logic [15:0] DCFG_WMASK = 16'hFE37;
    localparam logic [15:0] TXC_WMASK  = 16'hFC1F;

    // Values after reset (edge field is overlaid from the straps)
    localparam logic [15:0] DCFG_RESET = 16'h0000;
    localparam logic [15:0] TXC_RESET  = 16'h0000;
    localparam logic [1:0]  CTL_EDGE_RESET = 2'h0;

    // Cycles from an accepted write to the controlled outputs
    localparam int unsigned CTL_LATENCY = 2;

endpackage

// ==== core/phytxc_ctl_if.sv ====
/*
 * Control bundle from the register bank to its output stage.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface phytxc_ctl_if;
    logic       drive_high;  // Raised MII drive strength
    logic       show_symerr; // Receive error shows raw symbol error
    logic       low_power;   // Transmitter low power, zero output
    logic [1:0] edge_rate;   // Transmit rise time select

    // Register bank side
    modport src (output drive_high, show_symerr, low_power, edge_rate);
    // Output stage side
    modport dst (input drive_high, show_symerr, low_power, edge_rate);
endinterface

`default_nettype wire

// ==== core/phytxc_out_stage.sv ====
/*
 * Output stage: registers the control bits onto the pins that the
 * transmitter and MII pad logic use, and selects the receive error.
 * Assumes synchronous inputs and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module phytxc_out_stage (
    // Clock and reset
    input  wire logic     sys_clk_i,
    input  wire logic     srst_i,
    // Control from the register bank
    phytxc_ctl_if.dst     ctl,
    // Receive error sources
    input  wire logic     rx_err_normal_i,
    input  wire logic     rx_symbol_err_i,
    // Controlled outputs
    output logic          mii_drive_high_o,
    output logic          mii_rx_err_o,
    output logic          tx_low_power_o,
    output logic          tx_zero_diff_o,
    output logic [1:0]    tx_edge_rate_o
);

    // Pad and transmitter controls, one flop stage past the registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mii_drive_high_o <= 1'b0;
            tx_low_power_o   <= 1'b0;
            tx_zero_diff_o   <= 1'b0;
            tx_edge_rate_o   <= phytxc_pkg::CTL_EDGE_RESET;
        end else begin
            mii_drive_high_o <= ctl.drive_high;
            tx_low_power_o   <= ctl.low_power;
            tx_zero_diff_o   <= ctl.low_power;
            tx_edge_rate_o   <= ctl.edge_rate;
        end
    end

    // Receive error source select
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mii_rx_err_o <= 1'b0;
        end else if (ctl.show_symerr) begin
            mii_rx_err_o <= rx_symbol_err_i;
        end else begin
            mii_rx_err_o <= rx_err_normal_i;
        end
    end

    // Error pin follows the selected source one cycle later
    property p_rxer_select;
        @(posedge sys_clk_i) disable iff (srst_i)
        !$past(srst_i) |->
            mii_rx_err_o == ($past(ctl.show_symerr) ?
                             $past(rx_symbol_err_i) :
                             $past(rx_err_normal_i));
    endproperty
    a_rxer_select: assert property (p_rxer_select)
        else $error("receive error pin shows the wrong source");

    // Low power and zero differential always move together
    property p_lowpwr_pair;
        @(posedge sys_clk_i) disable iff (srst_i)
        tx_low_power_o == tx_zero_diff_o;
    endproperty
    a_lowpwr_pair: assert property (p_lowpwr_pair)
        else $error("low power without zero differential output");

endmodule

`default_nettype wire

// ==== verification/tb_phytxc_regs.sv ====
/*
 * Self-checking bench for the transmit configuration register bank.
 * Assumes the package and control interface are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_phytxc_regs;

    // Clock, reset and strap pins
    logic        sys_clk_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic [1:0]  strap     = 2'h2;
    // Register port
    logic [4:0]  addr      = 5'h00;
    logic        wr        = 1'b0;
    logic [15:0] wdata     = 16'h0000;
    logic        rd        = 1'b0;
    logic [15:0] rdata;
    logic        rvalid;
    // Receive error sources
    logic        err_norm  = 1'b0;
    logic        err_sym   = 1'b0;
    // Controlled outputs
    logic        drive_hi;
    logic        rx_err;
    logic        low_pwr;
    logic        zero_diff;
    logic [1:0]  edge_rate;
    // Counts and scratch
    int          miscompares = 0;
    int          comparisons = 0;
    logic [15:0] word;

    // 20 MHz clock
    always #25 sys_clk_i = ~sys_clk_i;

    // Device under test
    phytxc_regs dut_u (
        .sys_clk_i            (sys_clk_i),
        .srst_i               (srst_i),
        .tx_edge_rate_strap_i (strap),
        .reg_addr_i           (addr),
        .reg_wr_i             (wr),
        .reg_wdata_i          (wdata),
        .reg_rd_i             (rd),
        .reg_rdata_o          (rdata),
        .reg_rvalid_o         (rvalid),
        .rx_err_normal_i      (err_norm),
        .rx_symbol_err_i      (err_sym),
        .mii_drive_high_o     (drive_hi),
        .mii_rx_err_o         (rx_err),
        .tx_low_power_o       (low_pwr),
        .tx_zero_diff_o       (zero_diff),
        .tx_edge_rate_o       (edge_rate)
    );

    // Register word comparison
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                            input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got,
                     exp);
        end
    endtask

    // Pin level comparison
    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp,
                           input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %b not %b", $time, what, got,
                     exp);
        end
    endtask

    // Write, then wait until the outputs have followed
    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(negedge sys_clk_i);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge sys_clk_i);
        wr    = 1'b0;
        wdata = ~d;
        @(negedge sys_clk_i);
    endtask

    // Read with the fixed one-cycle answer
    task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
        @(negedge sys_clk_i);
        addr = a;
        rd   = 1'b1;
        @(negedge sys_clk_i);
        rd   = 1'b0;
        d    = rdata;
        chk_pin({1'b0, rvalid}, 2'h1, "read valid");
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the hundred or fewer cycles the tests need
    initial begin
        #(3000 * 50);
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end

    // Test sequence
    initial begin
        repeat (20) @(negedge sys_clk_i);
        srst_i = 1'b0;
        strap  = 2'h1; // Straps move after reset; field must not follow
        repeat (3) @(negedge sys_clk_i);
        chk_pin(edge_rate, 2'h2, "edge after reset");
        chk_pin({drive_hi, low_pwr}, 2'h0, "ctl after reset");
        reg_read(phytxc_pkg::DIG_CFG_ADDR, word);
        chk_word(word, 16'h0000, "dcfg reset");
        reg_read(phytxc_pkg::TX_CTL_ADDR, word);
        chk_word(word, 16'h0800, "txc reset");
        $display("test reset done");

        // All ones: read-only bits stay zero, controls go high
        reg_write(phytxc_pkg::DIG_CFG_ADDR, 16'hFFFF);
        reg_write(phytxc_pkg::TX_CTL_ADDR, 16'hFFFF);
        chk_pin({1'b0, drive_hi}, 2'h1, "drive high");
        chk_pin({low_pwr, zero_diff}, 2'h3, "low power");
        reg_read(phytxc_pkg::DIG_CFG_ADDR, word);
        chk_word(word, 16'hFE37, "dcfg ones");
        reg_read(phytxc_pkg::TX_CTL_ADDR, word);
        chk_word(word, 16'hFC1F, "txc ones");
        $display("test masks done");

        // Every rise time code, transmitter back to normal
        for (int c = 0; c < 4; c++) begin
            reg_write(phytxc_pkg::TX_CTL_ADDR, {4'h0, c[1:0], 10'h000});
            chk_pin(edge_rate, c[1:0], "edge code");
            chk_pin({low_pwr, zero_diff}, 2'h0, "normal tx");
        end
        $display("test edge codes done");

        // Receive error source select, both settings, all source levels
        for (int s = 0; s < 2; s++) begin
            reg_write(phytxc_pkg::DIG_CFG_ADDR, {6'h00, s[0], 9'h000});
            chk_pin({1'b0, drive_hi}, 2'h0, "drive normal");
            for (int p = 0; p < 4; p++) begin
                err_norm = p[0];
                err_sym  = p[1];
                @(negedge sys_clk_i);
                chk_pin({1'b0, rx_err}, {1'b0, p[s]}, "rxer");
            end
        end
        $display("test receive error done");

        // Unmapped address: write ignored, read gives zero
        reg_write(5'h1B, 16'hFFFF);
        reg_read(5'h1B, word);
        chk_word(word, 16'h0000, "unmapped");
        reg_read(phytxc_pkg::DIG_CFG_ADDR, word);
        chk_word(word, 16'h0200, "dcfg kept");
        $display("test unmapped done");

        // Second reset in mid-run with other straps
        reg_write(phytxc_pkg::DIG_CFG_ADDR, 16'h0800);
        @(negedge sys_clk_i);
        srst_i = 1'b1;
        strap  = 2'h3;
        repeat (2) @(negedge sys_clk_i);
        srst_i = 1'b0;
        strap  = 2'h0;
        repeat (3) @(negedge sys_clk_i);
        chk_pin(edge_rate, 2'h3, "edge re-reset");
        chk_pin({1'b0, drive_hi}, 2'h0, "drive re-reset");
        reg_read(phytxc_pkg::TX_CTL_ADDR, word);
        chk_word(word, 16'h0C00, "txc re-reset");
        reg_read(phytxc_pkg::DIG_CFG_ADDR, word);
        chk_word(word, 16'h0000, "dcfg re-reset");
        $display("test second reset done");
        end_of_test();
    end

endmodule

`default_nettype wire
